// file: hdl/acsb_pkg.sv
`default_nettype none
package acsb_pkg;
  // =====================================================
  // Register map
  localparam logic [7:0] ADDR_CFG_A = 8'h26;
  localparam logic [7:0] ADDR_CFG_B = 8'h27;
  localparam logic [7:0] ADDR_FILL  = 8'h30;
  localparam logic [7:0] ADDR_SYS   = 8'h31;
  localparam logic [7:0] ADDR_ASLP  = 8'h32;
  localparam logic [7:0] ADDR_PWR   = 8'h33;

  // =====================================================
  // Field positions
  localparam int BIT_ORDER     = 7;
  localparam int BIT_MODE_HI   = 6;
  localparam int BIT_MODE_LO   = 5;
  localparam int BIT_GATE      = 4;
  localparam int BIT_TRIG_IN   = 3;
  localparam int BIT_TRIG_OUT  = 2;
  localparam int BIT_TRIG_TILT = 0;
  localparam int BIT_FLUSH     = 7;
  localparam int BIT_WAKE_SRC  = 6;
  localparam int BIT_ACTIVE    = 0;
  localparam int BIT_EXT_SYNC  = 1;

  // =====================================================
  // Reset values and sizes
  localparam logic [7:0] CFG_A_RST  = 8'h00;
  localparam logic [6:0] CFG_B_RST  = 7'h00;
  localparam logic [7:0] ASLP_RST   = 8'h00;
  localparam logic [1:0] PWR_RST    = 2'h0;
  localparam logic [5:0] BUF_DEPTH  = 6'h20;

  // =====================================================
  // Modes and power states
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_STREAM = 2'h1,
    MODE_STOP   = 2'h2,
    MODE_TRIG   = 2'h3
  } acsb_mode_type;

  typedef enum logic [2:0] {
    PS_STBY  = 3'h1,
    PS_WAKE  = 3'h2,
    PS_SLEEP = 3'h4
  } acsb_pwr_type;
endpackage : acsb_pkg
`default_nettype wire

// file: hdl/acsb_fill_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acsb_fill_if;
  logic       store;
  logic       drop;
  logic       pop;
  logic       flush;
  logic       ovf_set;
  logic [5:0] wmrk;
  logic [5:0] cnt;
  logic       ovf;
  logic       wmk;
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  modport ctl (output store, drop, pop, flush, ovf_set, wmrk,
               input  cnt, ovf, wmk, wr_ptr, rd_ptr);
  modport trk (input  store, drop, pop, flush, ovf_set, wmrk,
               output cnt, ovf, wmk, wr_ptr, rd_ptr);
endinterface : acsb_fill_if
`default_nettype wire

// file: hdl/acsb_fill_track.sv
`timescale 1ns/1ps
`default_nettype none
module acsb_fill_track import acsb_pkg::*; (
  input  wire logic clk_in,
  input  wire logic rst_in,
  acsb_fill_if.trk  fi
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       ovf;
    logic       wmk;
    logic [4:0] wr;
    logic [4:0] rd;
  } acsb_trk_type;

  acsb_trk_type s_r;
  acsb_trk_type s_nxt;

  // =====================================================
  // Pointers and count
  always_comb begin
    s_nxt = s_r;
    if (fi.flush) begin
      s_nxt = '0; // [R20] [R07]
    end
    if (fi.pop && s_r.cnt == 6'h01 && !fi.store) begin
      s_nxt.ovf = 1'b0;
    end
    s_nxt.wr  = s_nxt.wr + 5'(fi.store);
    s_nxt.rd  = s_nxt.rd + 5'(fi.pop | fi.drop);
    s_nxt.cnt = s_nxt.cnt + 6'(fi.store) - 6'(fi.pop | fi.drop);
    // Set wins over a same-cycle flush
    s_nxt.ovf = s_nxt.ovf | fi.ovf_set;
    s_nxt.wmk = (fi.wmrk != 6'h00) && (s_nxt.cnt >= fi.wmrk); // [R19]
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign fi.cnt    = s_r.cnt;
  assign fi.ovf    = s_r.ovf;
  assign fi.wmk    = s_r.wmk;
  assign fi.wr_ptr = s_r.wr;
  assign fi.rd_ptr = s_r.rd;
endmodule : acsb_fill_track
`default_nettype wire

// file: hdl/acsb_sleep_timer.sv
`timescale 1ns/1ps
`default_nettype none
module acsb_sleep_timer import acsb_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         clear_in,
  input  wire logic         run_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] period_in,
  output logic              expire_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         exp;
  } acsb_tmr_type;

  acsb_tmr_type s_r;
  acsb_tmr_type s_nxt;

  // =====================================================
  // Output-rate period counter
  always_comb begin
    s_nxt = s_r;
    s_nxt.exp = 1'b0;
    if (clear_in || !run_in) begin
      s_nxt.cnt = '0;
    end else if (tick_in && period_in != '0) begin
      if (s_r.cnt == period_in - 1'b1) begin
        s_nxt.exp = 1'b1;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire_out = s_r.exp;
endmodule : acsb_sleep_timer
`default_nettype wire

// file: hdl/acsb_buf_ctrl.sv
// Functional notes
// R01: Bit 3 enables inside-limits trigger
// R02: Bit 2 enables outside-limits trigger
// R03: Bit 0 enables tilt-change trigger
// R04: Flush on disable, command, ungated wake/sleep
// R05: Flush on standby to active or sync
// R06: Gate set keeps contents across wake/sleep
// R07: Disable clears flags and sample count
// R08: Gate error and discard count cleared
// R09: Triggered auto-sleep: wake, then flush, sleep
// R10: Pre-trigger circular collection up to limit
// R11: After trigger stay awake, ignore triggers
// R12: Store remainder to full, flag, stop
// R13: Host empties buffer before next capture
// R14: Flush or empty re-arms; sleep first
// R15: Triggered auto-sleep ignores gate, flushes
// R16: Wake-holding events block triggered capture
// R17: Mode codes off, stream, stop, trigger
// R18: Flush command bit always reads zero
// R19: Zero limit suppresses fill level flag
// R20: Flush resets pointers and count together
`timescale 1ns/1ps
`default_nettype none
module acsb_buf_ctrl import acsb_pkg::*; #(
  parameter logic [5:0] DEPTH = BUF_DEPTH
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       sample_tick_in,
  input  wire logic       evt_inside_in,
  input  wire logic       evt_outside_in,
  input  wire logic       evt_tilt_in,
  input  wire logic       wake_event_in,
  input  wire logic       wake_hold_in,
  input  wire logic       host_pop_in,
  output logic            buf_store_out,
  output logic            buf_drop_out,
  output logic            buf_pop_out,
  output logic            buf_flush_out,
  output logic      [4:0] buf_wr_addr_out,
  output logic      [4:0] buf_rd_addr_out,
  output logic      [5:0] buf_count_out,
  output logic            store_full_flag_out,
  output logic            fill_level_flag_out,
  output logic      [2:0] pwr_state_out,
  output logic            lifo_sel_out
);
  typedef struct packed {
    logic [7:0]   cfg_a;
    logic [6:0]   cfg_b;
    logic [7:0]   aslp;
    logic [1:0]   pwr;
    acsb_pwr_type ps;
    logic         armed;
    logic         trig_done;
    logic         gate_closed;
    logic         gate_err;
    logic [4:0]   gate_cnt;
    logic [7:0]   rdata;
  } acsb_ctl_type;

  acsb_ctl_type  s_r;
  acsb_ctl_type  s_nxt;
  acsb_mode_type mode;
  logic [5:0]    wmrk;
  logic [5:0]    eff_cnt;
  logic          wr_a;
  logic          wr_b;
  logic          flush_cmd;
  logic          dis_wr;
  logic          ps_flush;
  logic          flush_any;
  logic          run_req;
  logic          trig_aslp;
  logic          hold;
  logic          trig_hit;
  logic          trig_acc;
  logic          accept;
  logic          gate_open;
  logic          st;
  logic          dr;
  logic          pp;
  logic          ovf_set;
  logic          discard;
  logic          emptied;
  logic          tmr_exp;

  acsb_fill_if fi ();

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ref_adr);
    return adr == ref_adr;
  endfunction : reg_hit

  // =====================================================
  // Submodules
  acsb_fill_track u_fill (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .fi     (fi.trk)
  );

  // Counting stops after a trigger so the capture is never cut short
  acsb_sleep_timer #(.W(8)) u_tmr (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .clear_in   (wake_event_in),
    .run_in     (s_r.ps == PS_WAKE && !hold && !s_r.trig_done), // [R11]
    .tick_in    (sample_tick_in),
    .period_in  (s_r.aslp),
    .expire_out (tmr_exp)
  );

  // =====================================================
  // Control
  always_comb begin
    s_nxt     = s_r;
    s_nxt.rdata = 8'h00;
    mode      = acsb_mode_type'(s_r.cfg_a[BIT_MODE_HI:BIT_MODE_LO]); // [R17]
    wmrk      = s_r.cfg_b[5:0];
    wr_a      = reg_wr_in && reg_hit(reg_addr_in, ADDR_CFG_A);
    wr_b      = reg_wr_in && reg_hit(reg_addr_in, ADDR_CFG_B);
    flush_cmd = wr_b && reg_wdata_in[BIT_FLUSH];
    dis_wr    = wr_a && reg_wdata_in[BIT_MODE_HI:BIT_MODE_LO] == MODE_OFF; // [R04]
    run_req   = s_r.pwr[BIT_ACTIVE] || s_r.pwr[BIT_EXT_SYNC];
    trig_aslp = mode == MODE_TRIG && s_r.aslp != 8'h00;
    // Flags only keep the part awake in stream and stop modes
    hold      = wake_hold_in || (s_r.cfg_b[BIT_WAKE_SRC] && (fi.ovf || fi.wmk)
                && (mode == MODE_STREAM || mode == MODE_STOP)); // [R16]
    trig_hit  = (evt_inside_in && s_r.cfg_a[BIT_TRIG_IN])     // [R01]
             || (evt_outside_in && s_r.cfg_a[BIT_TRIG_OUT])   // [R02]
             || (evt_tilt_in && s_r.cfg_a[BIT_TRIG_TILT]);    // [R03]
    // A capture needs a prior sleep when auto-sleep is in use
    trig_acc  = mode == MODE_TRIG && s_r.armed && !s_r.trig_done && trig_hit
             && (s_r.ps == PS_SLEEP || (s_r.aslp == 8'h00 && s_r.ps == PS_WAKE)); // [R16]

    ps_flush = 1'b0;
    unique case (s_r.ps)
      PS_STBY: begin
        if (run_req) begin
          s_nxt.ps = PS_WAKE;
          ps_flush = 1'b1; // [R05] [R09]
        end
      end
      PS_WAKE: begin
        if (!run_req) begin
          s_nxt.ps = PS_STBY;
        end else if (tmr_exp && !hold && !s_r.trig_done && s_r.aslp != 8'h00) begin
          s_nxt.ps = PS_SLEEP;
          ps_flush = !s_r.cfg_a[BIT_GATE] || trig_aslp; // [R04] [R09] [R15]
        end
      end
      PS_SLEEP: begin
        if (!run_req) begin
          s_nxt.ps = PS_STBY;
        end else if (wake_event_in || trig_acc) begin
          s_nxt.ps = PS_WAKE;
          // Pre-trigger samples must survive the trigger wake
          ps_flush = !s_r.cfg_a[BIT_GATE] && !trig_aslp; // [R04] [R10]
        end
      end
    endcase

    flush_any = flush_cmd || dis_wr || ps_flush;
    eff_cnt   = flush_any ? 6'h00 : fi.cnt;
    gate_open = flush_any || !s_r.gate_closed;
    accept    = sample_tick_in && s_r.ps != PS_STBY && mode != MODE_OFF && !dis_wr;
    pp        = host_pop_in && fi.cnt != 6'h00 && !flush_any;
    st        = 1'b0;
    dr        = 1'b0;
    ovf_set   = 1'b0;
    discard   = 1'b0;
    if (accept) begin
      if (!gate_open) begin
        discard = 1'b1; // [R06]
      end else begin
        unique case (mode)
          MODE_OFF: begin
          end
          MODE_STREAM: begin
            st = 1'b1;
            if (eff_cnt == DEPTH) begin
              dr      = !pp;
              ovf_set = 1'b1;
            end
          end
          MODE_STOP: begin
            if (eff_cnt < DEPTH || pp) begin
              st = 1'b1;
            end else begin
              ovf_set = 1'b1;
            end
          end
          MODE_TRIG: begin
            if (!s_r.trig_done && !trig_acc) begin
              if (wmrk != 6'h00) begin
                st = 1'b1;
                dr = eff_cnt >= wmrk && !pp; // [R10]
              end
            end else if (!fi.ovf && eff_cnt < DEPTH) begin
              st      = 1'b1;
              ovf_set = eff_cnt == DEPTH - 6'h01 && !pp; // [R12]
            end
          end
        endcase
      end
    end
    emptied = pp && fi.cnt == 6'h01 && !st;

    // Host must empty the capture before new data is taken
    if (flush_any || emptied) begin // [R13]
      s_nxt.armed       = 1'b1; // [R14]
      s_nxt.trig_done   = 1'b0;
      s_nxt.gate_closed = 1'b0;
      s_nxt.gate_err    = 1'b0; // [R08]
      s_nxt.gate_cnt    = 5'h00;
    end
    if (trig_acc) begin
      s_nxt.trig_done = 1'b1; // [R11]
      s_nxt.armed     = 1'b0;
    end
    if (s_r.ps != PS_STBY && s_nxt.ps != PS_STBY && s_nxt.ps != s_r.ps && !ps_flush
        && s_r.cfg_a[BIT_GATE] && !trig_aslp && fi.cnt != 6'h00) begin
      s_nxt.gate_closed = 1'b1; // [R06]
    end
    if (discard) begin
      s_nxt.gate_err = 1'b1;
      if (s_r.gate_cnt != 5'h1F) begin
        s_nxt.gate_cnt = s_r.gate_cnt + 5'h01;
      end
    end

    if (wr_a) begin
      s_nxt.cfg_a = reg_wdata_in;
    end
    if (wr_b) begin
      s_nxt.cfg_b = reg_wdata_in[6:0];
    end
    if (reg_wr_in && reg_hit(reg_addr_in, ADDR_ASLP)) begin
      s_nxt.aslp = reg_wdata_in;
    end
    if (reg_wr_in && reg_hit(reg_addr_in, ADDR_PWR)) begin
      s_nxt.pwr = reg_wdata_in[1:0];
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_CFG_A: s_nxt.rdata = s_r.cfg_a;
        ADDR_CFG_B: s_nxt.rdata = {1'b0, s_r.cfg_b}; // [R18]
        ADDR_FILL:  s_nxt.rdata = {fi.ovf, fi.wmk, fi.cnt};
        ADDR_SYS:   s_nxt.rdata = {s_r.gate_err, s_r.trig_done, s_r.armed, s_r.gate_cnt};
        ADDR_ASLP:  s_nxt.rdata = s_r.aslp;
        ADDR_PWR:   s_nxt.rdata = {3'h0, s_r.ps, s_r.pwr};
        default:    s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '{cfg_a: CFG_A_RST, cfg_b: CFG_B_RST, aslp: ASLP_RST, pwr: PWR_RST,
               ps: PS_STBY, armed: 1'b1, trig_done: 1'b0, gate_closed: 1'b0,
               gate_err: 1'b0, gate_cnt: 5'h00, rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================
  // Outputs
  assign fi.store      = st;
  assign fi.drop       = dr;
  assign fi.pop        = pp;
  assign fi.flush      = flush_any; // [R04] [R20]
  assign fi.ovf_set    = ovf_set;
  assign fi.wmrk       = wmrk;

  assign reg_rdata_out       = s_r.rdata;
  assign buf_store_out       = st;
  assign buf_drop_out        = dr;
  assign buf_pop_out         = pp;
  assign buf_flush_out       = flush_any;
  assign buf_wr_addr_out     = fi.wr_ptr;
  assign buf_rd_addr_out     = fi.rd_ptr;
  assign buf_count_out       = fi.cnt;
  assign store_full_flag_out = fi.ovf;
  assign fill_level_flag_out = fi.wmk;
  assign pwr_state_out       = s_r.ps;
  assign lifo_sel_out        = s_r.cfg_a[BIT_ORDER];

  // =====================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_trig_inside_gate: assert property ( // [R01]
    evt_inside_in && !s_r.cfg_a[BIT_TRIG_IN] && !evt_outside_in && !evt_tilt_in
    |-> !trig_acc) else $error("inside-limits trigger taken while disabled");
  a_trig_outside_gate: assert property ( // [R02]
    evt_outside_in && !s_r.cfg_a[BIT_TRIG_OUT] && !evt_inside_in && !evt_tilt_in
    |-> !trig_acc) else $error("outside-limits trigger taken while disabled");
  a_trig_tilt_gate: assert property ( // [R03]
    evt_tilt_in && !s_r.cfg_a[BIT_TRIG_TILT] && !evt_inside_in && !evt_outside_in
    |-> !trig_acc) else $error("tilt trigger taken while disabled");
  a_disable_clears: assert property ( // [R07]
    dis_wr |=> buf_count_out == 6'h00 && !store_full_flag_out && !fill_level_flag_out)
    else $error("disable left count or flags set");
  a_stby_flush: assert property ( // [R05]
    s_r.ps == PS_STBY && run_req |-> buf_flush_out ##1 s_r.ps == PS_WAKE)
    else $error("standby exit without flush");
  a_gate_keeps: assert property ( // [R06]
    s_r.ps == PS_WAKE && s_nxt.ps == PS_SLEEP && s_r.cfg_a[BIT_GATE] && !trig_aslp
    && !flush_cmd && !dis_wr |-> !buf_flush_out)
    else $error("gated transition flushed");
  a_gate_err_clr: assert property ( // [R08]
    buf_flush_out |=> !s_r.gate_err && s_r.gate_cnt == 5'h00)
    else $error("gate error survived flush");
  a_trig_stays_wake: assert property ( // [R11]
    s_r.trig_done && s_r.ps == PS_WAKE && run_req |=> s_r.ps == PS_WAKE)
    else $error("left wake after trigger");
  a_capture_stops: assert property ( // [R12]
    s_r.trig_done && store_full_flag_out && !buf_flush_out |-> !buf_store_out)
    else $error("stored after capture complete");
  a_sleep_flush_trig: assert property ( // [R15]
    trig_aslp && s_r.ps == PS_WAKE && s_nxt.ps == PS_SLEEP |-> buf_flush_out)
    else $error("triggered sleep entry without flush");
  a_hold_no_sleep: assert property ( // [R16]
    s_r.ps == PS_WAKE && wake_hold_in |=> s_r.ps != PS_SLEEP)
    else $error("slept while held awake");
  a_flush_reads_zero: assert property ( // [R18]
    reg_rd_in && reg_addr_in == ADDR_CFG_B |=> !reg_rdata_out[BIT_FLUSH])
    else $error("flush bit read as one");
  a_flush_rearms: assert property ( // [R14]
    buf_flush_out && !trig_acc |=> s_r.armed && !s_r.trig_done)
    else $error("flush did not re-arm");

  c_trigger: cover property (trig_acc ##1 s_r.ps == PS_WAKE);
  c_capture_full: cover property (s_r.trig_done && ovf_set);
  c_gate_discard: cover property (discard);
  c_wake_sleep: cover property (s_r.ps == PS_WAKE ##1 s_r.ps == PS_SLEEP);
endmodule : acsb_buf_ctrl
`default_nettype wire

// file: test/acsb_buf_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module acsb_buf_ctrl_bench import acsb_pkg::*; ;
  // =====================================================
  // Stimulus and observation
  logic       clk_in;
  logic       rst_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic       reg_wr_in;
  logic       reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic       sample_tick_in;
  logic       evt_inside_in;
  logic       evt_outside_in;
  logic       evt_tilt_in;
  logic       wake_event_in;
  logic       wake_hold_in;
  logic       host_pop_in;
  logic       buf_flush_out;
  logic       buf_store_out;
  logic       buf_drop_out;
  logic       buf_pop_out;
  logic       store_full_flag_out;
  logic       fill_level_flag_out;
  logic       lifo_sel_out;
  logic [4:0] buf_wr_addr_out;
  logic [4:0] buf_rd_addr_out;
  logic [5:0] buf_count_out;
  logic [2:0] pwr_state_out;
  logic [7:0] v;
  int         num_errors;
  int         samples_checked;
  int         flush_seen;
  int         store_seen;
  int         drop_seen;
  int         pop_seen;
  int         fl;
  int         n;
  int         cycles;
  int         seed;

  acsb_buf_ctrl dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sample_tick_in(sample_tick_in),
    .evt_inside_in(evt_inside_in), .evt_outside_in(evt_outside_in),
    .evt_tilt_in(evt_tilt_in), .wake_event_in(wake_event_in),
    .wake_hold_in(wake_hold_in), .host_pop_in(host_pop_in),
    .buf_store_out(buf_store_out), .buf_drop_out(buf_drop_out),
    .buf_pop_out(buf_pop_out),
    .buf_flush_out(buf_flush_out), .buf_wr_addr_out(buf_wr_addr_out),
    .buf_rd_addr_out(buf_rd_addr_out), .buf_count_out(buf_count_out),
    .store_full_flag_out(store_full_flag_out),
    .fill_level_flag_out(fill_level_flag_out),
    .pwr_state_out(pwr_state_out), .lifo_sel_out(lifo_sel_out)
  );

  always #10 clk_in = ~clk_in;

  // Flush pulses are combinational, so count them at the edge that samples them
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (buf_flush_out === 1'b1) begin
      flush_seen <= flush_seen + 1;
    end
    store_seen <= store_seen + int'(buf_store_out === 1'b1);
    drop_seen  <= drop_seen + int'(buf_drop_out === 1'b1);
    pop_seen   <= pop_seen + int'(buf_pop_out === 1'b1);
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // =====================================================
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic settle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : rd

  task automatic rdchk(input string w, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(w, d, e);
    if (a == ADDR_FILL) begin
      check("status_pins", {store_full_flag_out, fill_level_flag_out, buf_count_out}, e);
    end
  endtask : rdchk

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_in);
      sample_tick_in <= 1'b1;
      @(posedge clk_in);
      sample_tick_in <= 1'b0;
    end
  endtask : tick

  task automatic pop(input int k);
    repeat (k) begin
      @(posedge clk_in);
      host_pop_in <= 1'b1;
      @(posedge clk_in);
      host_pop_in <= 1'b0;
    end
  endtask : pop

  task automatic evt(input logic [2:0] m);
    @(posedge clk_in);
    {evt_inside_in, evt_outside_in, evt_tilt_in} <= m;
    @(posedge clk_in);
    {evt_inside_in, evt_outside_in, evt_tilt_in} <= 3'h0;
    settle(2);
  endtask : evt

  // Bounded wait: the sleep timer only advances on sample ticks
  task automatic to_sleep();
    for (int i = 0; i < 20 && pwr_state_out !== PS_SLEEP; i++) begin
      tick(1);
      settle(1);
    end
  endtask : to_sleep

  task automatic st_is(input logic [2:0] e);
    check("pwr_state", {5'h00, pwr_state_out}, {5'h00, e});
  endtask : st_is

  // Reference status byte {overflow, fill level, count}
  function automatic logic [7:0] stat(input int c, input int o, input int wm);
    return {o != 0, wm != 0 && c >= wm, 6'(c)};
  endfunction : stat

  // =====================================================
  // Main sequence
  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = 18'h00000;
    {sample_tick_in, evt_inside_in, evt_outside_in, evt_tilt_in} = 4'h0;
    {wake_event_in, wake_hold_in, host_pop_in} = 3'h0;
    {num_errors, samples_checked, flush_seen, cycles} = {32'h0, 32'h0, 32'h0, 32'h0};
    {store_seen, drop_seen, pop_seen} = {32'h0, 32'h0, 32'h0};
    seed = 15440;
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk("cfg_a", ADDR_CFG_A, CFG_A_RST);
    rdchk("status", ADDR_FILL, 8'h00);
    rdchk("pwr", ADDR_PWR, 8'h04);
    rdchk("unmapped", 8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      v[6:5] = 2'(i);
      wr(ADDR_CFG_A, v);
      rdchk("cfg_a", ADDR_CFG_A, v);
      check("lifo_sel", {7'h00, lifo_sel_out}, {7'h00, v[7]});
    end
    v = 8'($random(seed));
    wr(ADDR_CFG_B, v | 8'h80);
    rdchk("cfg_b", ADDR_CFG_B, v & 8'h7F);
    // =====================================================
    // Stream, flush command
    wr(ADDR_CFG_B, 8'h05);
    wr(ADDR_CFG_A, 8'h20);
    fl = flush_seen;
    wr(ADDR_PWR, 8'h01);
    settle(2);
    st_is(PS_WAKE);
    check("flushes", 8'(flush_seen - fl), 8'h01);
    n = 1 + int'($unsigned($random(seed)) % 40);
    tick(n);
    rdchk("status", ADDR_FILL, stat(n > 32 ? 32 : n, n > 32, 5));
    check("stores", 8'(store_seen), 8'(n));
    check("drops", 8'(drop_seen), 8'(n > 32 ? n - 32 : 0));
    fl = flush_seen;
    wr(ADDR_CFG_B, 8'h85);
    settle(1);
    check("wr_ptr", {3'h0, buf_wr_addr_out}, 8'h00);
    check("rd_ptr", {3'h0, buf_rd_addr_out}, 8'h00);
    check("flushes", 8'(flush_seen - fl), 8'h01);
    rdchk("status", ADDR_FILL, 8'h00);
    // Stop mode, zero limit, full read-out
    wr(ADDR_CFG_B, 8'h00);
    wr(ADDR_CFG_A, 8'h40);
    tick(34);
    rdchk("status", ADDR_FILL, stat(32, 1, 0));
    check("stores", 8'(store_seen - n), 8'h20);
    pop(32);
    rdchk("status", ADDR_FILL, 8'h00);
    check("pops", 8'(pop_seen), 8'h20);
    // Disable
    wr(ADDR_CFG_B, 8'h05);
    wr(ADDR_CFG_A, 8'h20);
    tick(7);
    rdchk("status", ADDR_FILL, stat(7, 0, 5));
    fl = flush_seen;
    wr(ADDR_CFG_A, 8'h00);
    rdchk("status", ADDR_FILL, 8'h00);
    check("flushes", 8'(flush_seen - fl), 8'h01);
    // =====================================================
    // Gate open and closed across wake/sleep
    for (int g = 0; g < 2; g++) begin
      wr(ADDR_PWR, 8'h00);
      wr(ADDR_ASLP, 8'h02);
      wr(ADDR_CFG_A, g ? 8'h30 : 8'h20);
      wr(ADDR_PWR, 8'h01);
      tick(1);
      fl = flush_seen;
      to_sleep();
      st_is(PS_SLEEP);
      check("flushes", 8'(flush_seen - fl), g ? 8'h00 : 8'h01);
      if (g == 1) begin
        tick(1);
        rd(ADDR_SYS, v);
        check("gate_err", {7'h00, v[7]}, 8'h01);
        wr(ADDR_CFG_B, 8'h85);
        rd(ADDR_SYS, v);
        check("gate_err", {7'h00, v[7]}, 8'h00);
      end else begin
        fl = flush_seen;
        @(posedge clk_in);
        wake_event_in <= 1'b1;
        @(posedge clk_in);
        wake_event_in <= 1'b0;
        settle(2);
        st_is(PS_WAKE);
        check("flushes", 8'(flush_seen - fl), 8'h01);
      end
    end
    // =====================================================
    // Triggered capture; gate set to show it is ignored
    wr(ADDR_PWR, 8'h00);
    wr(ADDR_ASLP, 8'h03);
    wr(ADDR_CFG_B, 8'h04);
    wr(ADDR_CFG_A, 8'h78);
    wr(ADDR_PWR, 8'h01);
    settle(2);
    st_is(PS_WAKE);
    fl = flush_seen;
    to_sleep();
    st_is(PS_SLEEP);
    check("flushes", 8'(flush_seen - fl), 8'h01);
    tick(6);
    rdchk("status", ADDR_FILL, stat(4, 0, 4));
    evt(3'b010);
    st_is(PS_SLEEP);
    evt(3'b001);
    st_is(PS_SLEEP);
    evt(3'b100);
    st_is(PS_WAKE);
    tick(40);
    rdchk("status", ADDR_FILL, stat(32, 1, 4));
    st_is(PS_WAKE);
    evt(3'b100);
    rd(ADDR_SYS, v);
    check("armed", {7'h00, v[5]}, 8'h00);
    fl = flush_seen;
    wr(ADDR_CFG_B, 8'h84);
    rd(ADDR_SYS, v);
    check("done_armed", {6'h00, v[6:5]}, 8'h01);
    to_sleep();
    st_is(PS_SLEEP);
    check("flushes", 8'(flush_seen - fl), 8'h02);
    // Armed in sleep, inside-limits source now off, tilt on
    wr(ADDR_CFG_A, 8'h71);
    evt(3'b100);
    st_is(PS_SLEEP);
    // Held awake: no sleep, so no capture
    @(posedge clk_in);
    wake_hold_in <= 1'b1;
    wr(ADDR_PWR, 8'h00);
    wr(ADDR_PWR, 8'h01);
    tick(10);
    evt(3'b001);
    st_is(PS_WAKE);
    rd(ADDR_SYS, v);
    check("trig_done", {7'h00, v[6]}, 8'h00);
    print_verdict();
  end
endmodule : acsb_buf_ctrl_bench
`default_nettype wire
